// [src/dmem_map.sv]
// Data memory map: region decode, paged user RAM, page select and stack.
// ********************************************************************
// ********************************************************************
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "dmem_map_params.svh"
module dmem_map
  import dmem_map_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SET_PAGE_FLAG_INSTR,
  input wire logic CLEAR_PAGE_FLAG_INSTR,
  input wire logic LOAD_SP,
  input wire logic [7:0] SP_DATA,
  input wire logic CALL_REQ,
  input wire logic INT_REQ,
  input wire logic [15:0] RET_PC,
  input wire logic [7:0] FLAGS_IN,
  input wire logic SUBROUTINE_RETURN_INSTR,
  input wire logic INTERRUPT_RETURN_INSTR,
  output logic STACK_BUSY,
  output logic STACK_DONE,
  output logic [15:0] POP_PC,
  output logic [7:0] POP_FLAGS,
  output logic POP_FLAGS_VALID,
  output logic [7:0] STACK_POINTER,
  output logic PAGE_FLAG,
  output logic [3:0] REGION,
  output logic PERIPH_WR,
  output logic PERIPH_RD,
  output logic [7:0] PERIPH_ADDR,
  output logic [7:0] PERIPH_WDATA,
  input wire logic [7:0] PERIPH_RDATA,
  input wire logic PERIPH_HIT,
  input wire logic [7:0] TIMER0_COUNT,
  input wire logic [7:0] TIMER0_CAPTURE_VALUE,
  input wire logic TIMER0_CAPTURE_SEL,
  output logic TIMER0_COMPARE_DATA_WR,
  input wire logic [7:0] WATCHDOG_COUNT_VALUE,
  output logic WATCHDOG_CONTROL_WR,
  output logic LCD_WR,
  output logic [7:0] LCD_ADDR,
  input wire logic [7:0] LCD_RDATA
);
  dmem_ram_if ram ();

  // ******************************************************************
  // Region decode
  // ******************************************************************

  // Classify a 16-bit address; used for bus accesses only, the stack sequencer does not decode.
  function automatic region_t decode(input logic [15:0] a);
    if (a >= `STACK_LO && a <= `STACK_HI) begin
      decode = RGN_STACK;
    end else if (a >= `LCD_LO && a <= `LCD_HI) begin
      decode = RGN_LCD;
    end else if (a >= `CTRL_WIN_LO && a <= `CTRL_WIN_HI) begin
      decode = RGN_CTRL;
    end else begin
      decode = RGN_RAM;
    end
  endfunction : decode

  region_t rgn;
  logic page_hit;
  assign rgn = decode(ADDR);
  assign page_hit = (rgn == RGN_CTRL) && (ADDR[7:0] == `PAGE_SEL_ADDR);

  // ******************************************************************
  // Page flag and page select
  // ******************************************************************
  logic [2:0] page_sel_ff, nxt_page_sel;
  logic flag_ff, nxt_flag;

  // Byte writes and bit read-modify-writes both arrive as a byte write,
  // so the page select stays bit-addressable.
  always_comb begin
    nxt_page_sel = page_sel_ff;
    nxt_flag = flag_ff;
    if (WR && page_hit) begin
      nxt_page_sel = WDATA[`PAGE_SEL_MSB:0];
    end
    if (SET_PAGE_FLAG_INSTR) begin
      nxt_flag = 1'b1;
    end else if (CLEAR_PAGE_FLAG_INSTR) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      page_sel_ff <= `PAGE_SEL_RESET;
      flag_ff <= 1'b0;
    end else if (CE) begin
      page_sel_ff <= nxt_page_sel;
      flag_ff <= nxt_flag;
    end
  end
  assign PAGE_FLAG = flag_ff;

  // Page 1 sits above page 0 and shares its bytes with the stack; page 4
  // and unassigned codes fold onto page 0 so the stack page stays safe.
  function automatic logic [7:0] ram_index(input logic [2:0] pg,
                                           input logic [7:0] lo);
    unique case (pg)
      `PAGE_CODE_1: ram_index = `RAM_PAGE1_BASE + lo;
      `PAGE_CODE_4: ram_index = lo;
      default: ram_index = lo;
    endcase
  endfunction : ram_index

  logic [2:0] eff_page;
  assign eff_page = (rgn == RGN_STACK) ? `PAGE_CODE_1 :
                    flag_ff ? page_sel_ff : `PAGE_CODE_0;

  // ******************************************************************
  // Stack sequencer
  // ******************************************************************
  stk_state_t st_ff, nxt_st;
  logic [7:0] sp_ff, nxt_sp;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [1:0] last_ff, nxt_last;
  logic push_ff, nxt_push;
  logic irq_ff, nxt_irq;
  logic [7:0] b_ff [3];
  logic [7:0] nxt_b [3];
  logic pend_ff, nxt_pend;

  // Stack bytes for a push: PCH, PCL, then flags for an interrupt.
  function automatic logic [7:0] push_byte(input logic [1:0] i,
                                           input logic [15:0] pc,
                                           input logic [7:0] f);
    unique case (i)
      2'd0: push_byte = pc[15:8];
      2'd1: push_byte = pc[7:0];
      default: push_byte = f;
    endcase
  endfunction : push_byte

  logic stk_we;
  logic [7:0] stk_addr;
  always_comb begin
    nxt_st = st_ff;
    nxt_sp = sp_ff;
    nxt_cnt = cnt_ff;
    nxt_last = last_ff;
    nxt_push = push_ff;
    nxt_irq = irq_ff;
    nxt_b = b_ff;
    nxt_pend = 1'b0;
    stk_we = 1'b0;
    stk_addr = sp_ff;
    if (LOAD_SP) begin
      nxt_sp = SP_DATA;
    end
    unique case (st_ff)
      ST_IDLE: begin
        nxt_cnt = 2'd0;
        if (CALL_REQ || INT_REQ) begin
          nxt_st = ST_PUSH;
          nxt_irq = INT_REQ;
          nxt_last = INT_REQ ? 2'd2 : 2'd1;
          nxt_push = 1'b1;
        end else if (SUBROUTINE_RETURN_INSTR || INTERRUPT_RETURN_INSTR) begin
          nxt_st = ST_POP;
          nxt_irq = INTERRUPT_RETURN_INSTR;
          nxt_last = INTERRUPT_RETURN_INSTR ? 2'd2 : 2'd1;
          nxt_push = 1'b0;
        end
      end
      ST_PUSH: begin
        // Write at the pointer, then step down: pointer names next free.
        stk_we = 1'b1;
        nxt_sp = sp_ff - 8'd1;
        nxt_cnt = cnt_ff + 2'd1;
        if (cnt_ff == last_ff) begin
          nxt_st = ST_DONE;
        end
      end
      ST_POP: begin
        // Step up first, then read; data lands one cycle later.
        stk_addr = sp_ff + 8'd1;
        nxt_sp = sp_ff + 8'd1;
        nxt_pend = 1'b1;
        nxt_cnt = cnt_ff + 2'd1;
        if (cnt_ff == last_ff) begin
          nxt_st = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!pend_ff) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // Pop order is the reverse of push: flags, PCL, PCH.
    if (pend_ff) begin
      nxt_b[last_ff - (cnt_ff - 2'd1)] = ram.rdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 2'd0;
      last_ff <= 2'd0;
      push_ff <= 1'b0;
      irq_ff <= 1'b0;
      pend_ff <= 1'b0;
      b_ff <= '{default: 8'h00};
    end else if (CE) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      last_ff <= nxt_last;
      push_ff <= nxt_push;
      irq_ff <= nxt_irq;
      pend_ff <= nxt_pend;
      b_ff <= nxt_b;
    end
  end

  // The pointer is deliberately not reset; software must load it.
  always_ff @(posedge SYS_CLK) begin
    if (CE) begin
      sp_ff <= nxt_sp;
    end
  end

  assign STACK_BUSY = (st_ff != ST_IDLE);
  assign STACK_DONE = (st_ff == ST_DONE) && !pend_ff;
  assign STACK_POINTER = sp_ff;
  assign POP_PC = {b_ff[0], b_ff[1]};
  assign POP_FLAGS = b_ff[2];
  assign POP_FLAGS_VALID = STACK_DONE && !push_ff && irq_ff;

  // ******************************************************************
  // RAM port and peripheral steering
  // ******************************************************************
  logic ram_wr;
  assign ram_wr = WR && (rgn == RGN_RAM || rgn == RGN_STACK);
  logic [7:0] push_data;
  assign push_data = push_byte(cnt_ff, RET_PC, FLAGS_IN);

  // The stack sequencer owns the RAM while busy; the core stalls then.
  always_comb begin
    if (STACK_BUSY) begin
      ram.we = stk_we;
      ram.addr = ram_index(`PAGE_CODE_1, stk_addr);
      ram.wdata = push_data;
    end else begin
      ram.we = ram_wr;
      ram.addr = ram_index(eff_page, ADDR[7:0]);
      ram.wdata = WDATA;
    end
  end

  dmem_ram #(.DEPTH(`RAM_DEPTH)) u_ram (
    .clk(SYS_CLK),
    .ce(CE),
    .bus(ram.mem)
  );

  // Special shared addresses split reads and writes to different targets.
  logic t0_hit, wd_hit;
  assign t0_hit = (rgn == RGN_CTRL) && (ADDR[7:0] == `TIMER0_ADDR);
  assign wd_hit = (rgn == RGN_CTRL) && (ADDR[7:0] == `WATCHDOG_ADDR);
  assign TIMER0_COMPARE_DATA_WR = WR && t0_hit;
  assign WATCHDOG_CONTROL_WR = WR && wd_hit;
  // Byte-only registers see only whole-byte writes; no bit merge here.
  assign PERIPH_WR = WR && (rgn == RGN_CTRL) && !page_hit;
  assign PERIPH_RD = RD && (rgn == RGN_CTRL);
  assign PERIPH_ADDR = ADDR[7:0];
  assign PERIPH_WDATA = WDATA;
  assign LCD_WR = WR && (rgn == RGN_LCD);
  assign LCD_ADDR = ADDR[7:0];
  assign REGION = rgn;

  // ******************************************************************
  // Read data return
  // ******************************************************************
  region_t rrgn_ff, nxt_rrgn;
  logic [7:0] ctrl_ff, nxt_ctrl;

  // Control-window data is captured at the read; RAM data comes from
  // the registered array port in the following cycle.
  always_comb begin
    nxt_rrgn = rgn;
    nxt_ctrl = 8'h00;
    if (page_hit) begin
      nxt_ctrl = {5'b0_0000, page_sel_ff};
    end else if (t0_hit) begin
      nxt_ctrl = TIMER0_CAPTURE_SEL ? TIMER0_CAPTURE_VALUE
                                    : TIMER0_COUNT;
    end else if (wd_hit) begin
      nxt_ctrl = WATCHDOG_COUNT_VALUE;
    end else if (PERIPH_HIT) begin
      nxt_ctrl = PERIPH_RDATA;
    end
    if (rgn == RGN_LCD) begin
      nxt_ctrl = LCD_RDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rrgn_ff <= RGN_RAM;
      ctrl_ff <= 8'h00;
    end else if (CE) begin
      rrgn_ff <= nxt_rrgn;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign RDATA = (rrgn_ff == RGN_RAM || rrgn_ff == RGN_STACK) ?
                 ram.rdata : ctrl_ff;
endmodule : dmem_map

// [src/dmem_map_params.svh]
// Address map, field positions, reset values and sizes of the data memory map.
`ifndef DMEM_MAP_PARAMS_SVH
`define DMEM_MAP_PARAMS_SVH
`define CTRL_WIN_LO 16'h00A0
`define CTRL_WIN_HI 16'h00FF
`define STACK_LO 16'h0100
`define STACK_HI 16'h015F
`define LCD_LO 16'h0F80
`define LCD_HI 16'h0F9A
`define PAGE_SEL_ADDR 8'hCF
`define PAGE_SEL_RESET 3'h1
`define PAGE_SEL_MSB 2
`define TIMER0_ADDR 8'hD1
`define WATCHDOG_ADDR 8'hE8
`define PAGE_CODE_0 3'h0
`define PAGE_CODE_1 3'h1
`define PAGE_CODE_4 3'h4
`define RAM_DEPTH 256
`define STACK_PAGE 8'h01
`define RAM_PAGE1_BASE 8'hA0
`define PAGE_FLAG_ADDR 8'hF4
`endif

// [src/dmem_map_pkg.sv]
// Types shared by the data memory map.
package dmem_map_pkg;
  typedef enum logic [3:0] {
    RGN_RAM = 4'b0001,
    RGN_CTRL = 4'b0010,
    RGN_STACK = 4'b0100,
    RGN_LCD = 4'b1000
  } region_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PUSH = 4'b0010,
    ST_POP = 4'b0100,
    ST_DONE = 4'b1000
  } stk_state_t;
endpackage : dmem_map_pkg

// [src/dmem_ram.sv]
// User RAM array with registered read data.
`timescale 1ns/1ps
module dmem_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic ce,
  dmem_ram_if.mem bus
);
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;

  // Read port is synchronous so the array maps onto block RAM.
  always_comb begin
    nxt_rd = mem_ff[bus.addr];
  end

  // No reset on the array: user RAM content is undefined at power-up.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (bus.we) begin
        mem_ff[bus.addr] <= bus.wdata;
      end
      rd_ff <= nxt_rd;
    end
  end

  assign bus.rdata = rd_ff;
endmodule : dmem_ram

// [src/dmem_ram_if.sv]
// Interface between the map decoder and its RAM array.
`timescale 1ns/1ps
interface dmem_ram_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : dmem_ram_if

// [test/data_memory_paging_map_test.sv]
// Self-checking bench for the data memory map.
`timescale 1ns/1ps
module data_memory_paging_map_test;
  // ********
  // Design and partner
  // ********
  localparam logic [7:0] T0C = 8'h33;
  localparam logic [7:0] T0K = 8'hC3;
  localparam logic [7:0] WDC = 8'h6E;
  logic clk, rst_n, ce, wr_s, rd_s, t0_sel, done, fv, pflag, p_hit;
  logic [15:0] addr, ret_pc, pop_pc;
  logic [7:0] wdata, rdata, sp_data, flags_in, pop_flags, sp, p_addr;
  logic [7:0] p_rdata, t0_cnt, t0_cap, wdt_cnt, lcd_addr, lcd_rd;
  logic [6:0] ctl;
  logic [3:0] region;
  logic [7:0] pg [3] = '{8'h00, 8'h01, 8'h04};
  logic [15:0] ra [4] = '{16'h0035, 16'h00A0, 16'h015F, 16'h0F80};
  logic [3:0] rg [4] = '{4'b0001, 4'b0010, 4'b0100, 4'b1000};
  int n_errors, samples_checked;
  logic p_wr, p_rd, l_wr;
  logic [7:0] p_wd, last_pwd;
  int n_pwr, n_prd, n_lwr;

  dmem_map u_dmem_map (.SYS_CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .SET_PAGE_FLAG_INSTR(ctl[0]), .CLEAR_PAGE_FLAG_INSTR(ctl[1]),
    .LOAD_SP(ctl[2]), .SP_DATA(sp_data), .CALL_REQ(ctl[3]),
    .INT_REQ(ctl[4]), .RET_PC(ret_pc), .FLAGS_IN(flags_in),
    .SUBROUTINE_RETURN_INSTR(ctl[5]), .INTERRUPT_RETURN_INSTR(ctl[6]),
    .STACK_BUSY(), .STACK_DONE(done), .POP_PC(pop_pc),
    .POP_FLAGS(pop_flags), .POP_FLAGS_VALID(fv), .STACK_POINTER(sp),
    .PAGE_FLAG(pflag), .REGION(region), .PERIPH_WR(p_wr), .PERIPH_RD(p_rd),
    .PERIPH_ADDR(p_addr), .PERIPH_WDATA(p_wd), .PERIPH_RDATA(p_rdata),
    .PERIPH_HIT(p_hit), .TIMER0_COUNT(t0_cnt),
    .TIMER0_CAPTURE_VALUE(t0_cap), .TIMER0_CAPTURE_SEL(t0_sel),
    .TIMER0_COMPARE_DATA_WR(), .WATCHDOG_COUNT_VALUE(wdt_cnt),
    .WATCHDOG_CONTROL_WR(), .LCD_WR(l_wr), .LCD_ADDR(lcd_addr),
    .LCD_RDATA(lcd_rd));

  dmem_periph_model #(.CNT(T0C), .CAP(T0K), .WDC(WDC)) u_dmem_periph_model (
    .periph_addr(p_addr), .lcd_addr(lcd_addr), .periph_rdata(p_rdata),
    .periph_hit(p_hit), .timer0_count(t0_cnt), .timer0_capture_value(t0_cap),
    .watchdog_count_value(wdt_cnt), .lcd_rdata(lcd_rd));

  // 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Tally the strobes handed to peripherals and display; they last a cycle.
  always @(posedge clk) begin
    if (p_wr) begin
      n_pwr <= n_pwr + 1;
      last_pwd <= p_wd;
    end
    if (p_rd) begin
      n_prd <= n_prd + 1;
    end
    if (l_wr) begin
      n_lwr <= n_lwr + 1;
    end
  end

  // ********
  // Bus tasks
  // ********
  // Compare with case equality so an unknown never matches.
  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stand from the cycle after the strobe for as long as the address holds.
  task automatic rd(input logic [15:0] a, input logic [7:0] e, string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask : rd

  // One-cycle control pulse; stack operations wait for done, bounded.
  task automatic stk(input logic [6:0] m, input logic efv);
    int i;
    @(posedge clk);
    ctl <= m;
    @(posedge clk);
    ctl <= '0;
    if (m > 7'h07) begin
      for (i = 0; i < 12 && done !== 1'b1; i++) @(posedge clk) #1;
      chk("done", done, 1'b1);
      chk("flags valid", fv, efv);
    end
    @(posedge clk) #1;
  endtask : stk

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ********
  // Tests
  // ********
  initial begin
    {rst_n, wr_s, rd_s, t0_sel, ctl, addr, wdata} = '0;
    {sp_data, ret_pc, flags_in} = '0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h00CF, 8'h01, "page select reset");
    chk("page flag reset", pflag, 1'b0);
    $display("test reset done");
    wr(16'h00CF, 8'hFC);
    rd(16'h00CF, 8'h04, "page select upper");
    foreach (pg[k]) begin
      wr(16'h00CF, pg[k]);
      rd(16'h00CF, pg[k], "page code");
    end
    wr(16'h0035, 8'h3C);
    rd(16'h0035, 8'h3C, "ram");
    wr(16'h00CF, 8'h01);
    stk(7'h01, 1'b0);
    chk("flag set", pflag, 1'b1);
    wr(16'h0035, 8'h77);
    rd(16'h0035, 8'h77, "paged ram");
    rd(16'h0135, 8'h77, "page one");
    stk(7'h02, 1'b0);
    chk("flag clear", pflag, 1'b0);
    rd(16'h0035, 8'h3C, "page zero ram");
    stk(7'h03, 1'b0);
    chk("set wins", pflag, 1'b1);
    $display("test paging done");
    foreach (ra[k]) begin
      @(posedge clk);
      addr <= ra[k];
      #1 chk("region", region, rg[k]);
    end
    rd(16'h00C0, 8'hC0 ^ 8'h5A, "control read");
    rd(16'h00D1, T0C, "timer count");
    t0_sel <= 1'b1;
    rd(16'h00D1, T0K, "timer capture");
    wr(16'h00D1, 8'h10);
    wr(16'h00E8, 8'h7F);
    rd(16'h00E8, WDC, "watchdog count");
    wr(16'h0F85, 8'h0F);
    rd(16'h0F85, 8'h85 ^ 8'hA5, "display read");
    chk("display writes", n_lwr, 1);
    chk("periph writes", n_pwr, 2);
    chk("periph data", last_pwd, 8'h7F);
    chk("periph reads", n_prd, 9);
    $display("test control done");
    sp_data <= 8'h5F;
    stk(7'h04, 1'b0);
    chk("pointer load", sp, 8'h5F);
    ret_pc <= 16'h1234;
    stk(7'h08, 1'b0);
    chk("pointer call", sp, 8'h5D);
    rd(16'h015F, 8'h12, "pushed high byte");
    stk(7'h20, 1'b0);
    chk("return pc", pop_pc, 16'h1234);
    chk("pointer return", sp, 8'h5F);
    ret_pc <= 16'hABCD;
    flags_in <= 8'hA5;
    stk(7'h10, 1'b0);
    chk("pointer int", sp, 8'h5C);
    stk(7'h40, 1'b1);
    chk("int return pc", pop_pc, 16'hABCD);
    chk("int return flags", pop_flags, 8'hA5);
    chk("pointer int return", sp, 8'h5F);
    $display("test stack done");
    conclude();
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    #80000;
    n_errors++;
    conclude();
  end
endmodule : data_memory_paging_map_test

// [test/dmem_map_checker.sv]
// Concurrent checks on the ports of the data memory map.
`timescale 1ns/1ps
module dmem_map_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SET_PAGE_FLAG_INSTR,
  input wire logic CLEAR_PAGE_FLAG_INSTR,
  input wire logic CALL_REQ,
  input wire logic INTERRUPT_RETURN_INSTR,
  input wire logic STACK_BUSY,
  input wire logic STACK_DONE,
  input wire logic POP_FLAGS_VALID,
  input wire logic [7:0] STACK_POINTER,
  input wire logic PAGE_FLAG,
  input wire logic [3:0] REGION,
  input wire logic [7:0] TIMER0_COUNT,
  input wire logic [7:0] TIMER0_CAPTURE_VALUE,
  input wire logic TIMER0_CAPTURE_SEL,
  input wire logic TIMER0_COMPARE_DATA_WR,
  input wire logic [7:0] WATCHDOG_COUNT_VALUE,
  input wire logic WATCHDOG_CONTROL_WR
);
  // ********
  // Checks
  // ********
  // All checks share one clock and are idle while reset is held.
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_flag_set: assert property (CE && SET_PAGE_FLAG_INSTR |=> PAGE_FLAG)
    else $error("page flag not set");
  a_flag_clr: assert property (CE && CLEAR_PAGE_FLAG_INSTR &&
    !SET_PAGE_FLAG_INSTR |=> !PAGE_FLAG) else $error("page flag not clear");
  a_t0_wr: assert property (CE && WR && ADDR == 16'h00D1 |->
    TIMER0_COMPARE_DATA_WR) else $error("compare write missing");
  a_t0_rd: assert property (CE && RD && ADDR == 16'h00D1 |=>
    RDATA == ($past(TIMER0_CAPTURE_SEL) ? $past(TIMER0_CAPTURE_VALUE) :
    $past(TIMER0_COUNT))) else $error("timer read wrong");
  a_wdt_wr: assert property (CE && WR && ADDR == 16'h00E8 |->
    WATCHDOG_CONTROL_WR) else $error("watchdog write missing");
  a_wdt_rd: assert property (CE && RD && ADDR == 16'h00E8 |=>
    RDATA == $past(WATCHDOG_COUNT_VALUE)) else $error("watchdog read");
  a_sel_upper: assert property (CE && RD && ADDR == 16'h00CF |=>
    RDATA[7:3] == 5'h00) else $error("page select upper bits");
  a_ctrl_rgn: assert property (ADDR inside {[16'h00A0:16'h00FF]} |->
    REGION == 4'b0010) else $error("control region");
  a_stack_rgn: assert property (ADDR inside {[16'h0100:16'h015F]} |->
    REGION == 4'b0100) else $error("stack region");
  a_call_push: assert property (CE && CALL_REQ && !STACK_BUSY |=>
    STACK_BUSY [*2] ##1 STACK_DONE) else $error("call push timing");
  a_call_sp: assert property (CE && CALL_REQ && !STACK_BUSY |->
    ##3 STACK_POINTER == $past(STACK_POINTER, 3) - 8'h02)
    else $error("pointer after call");
  a_flags_pair: assert property (POP_FLAGS_VALID |-> STACK_DONE)
    else $error("flags valid without done");
  a_iret_flags: assert property (CE && INTERRUPT_RETURN_INSTR &&
    !STACK_BUSY |-> ##[2:8] POP_FLAGS_VALID) else $error("no flags pop");

  // Main scenarios seen at least once.
  c_call: cover property (CE && CALL_REQ);
  c_iret: cover property (POP_FLAGS_VALID);
  c_flag: cover property ($rose(PAGE_FLAG));
endmodule : dmem_map_checker

bind dmem_map dmem_map_checker u_dmem_map_checker (.*);

// [test/dmem_periph_model.sv]
// Peripheral side model answering the control window, timer and display.
`timescale 1ns/1ps
module dmem_periph_model #(
  parameter logic [7:0] CNT = 8'h33,
  parameter logic [7:0] CAP = 8'hC3,
  parameter logic [7:0] WDC = 8'h6E
) (
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] lcd_addr,
  output logic [7:0] periph_rdata,
  output logic periph_hit,
  output logic [7:0] timer0_count,
  output logic [7:0] timer0_capture_value,
  output logic [7:0] watchdog_count_value,
  output logic [7:0] lcd_rdata
);
  // Read data follow the address, so a stale or swapped path shows.
  assign periph_rdata = periph_addr ^ 8'h5A;
  assign periph_hit = 1'b1;
  assign lcd_rdata = lcd_addr ^ 8'hA5;
  // Count and capture differ so a wrong selection is visible.
  assign timer0_count = CNT;
  assign timer0_capture_value = CAP;
  assign watchdog_count_value = WDC;
endmodule : dmem_periph_model
